// >>> shared/abeu_pkg.sv
package abeu_pkg;

   // --------------------------------------------------------------
   // status flag positions and reset values
   // --------------------------------------------------------------
   localparam int ABEU_FLAG_C = 0;
   localparam int ABEU_FLAG_Z = 1;
   localparam int ABEU_FLAG_N = 2;
   localparam int ABEU_FLAG_V = 3;
   localparam int ABEU_FLAG_S = 4;
   localparam int ABEU_FLAG_H = 5;
   localparam int ABEU_FLAG_T = 6;
   localparam int ABEU_FLAG_I = 7;
   localparam logic [7:0] ABEU_STATUS_RST = 8'h00;
   localparam logic [15:0] ABEU_PC_RST = 16'h0000;
   localparam logic [7:0] ABEU_ALL_ONES = 8'hff;
   localparam logic [7:0] ABEU_ONE = 8'h01;

   // --------------------------------------------------------------
   // cycle counts per instruction class
   // --------------------------------------------------------------
   localparam logic [2:0] ABEU_CYC_ONE = 3'h1;
   localparam logic [2:0] ABEU_CYC_TWO = 3'h2;
   localparam logic [2:0] ABEU_CYC_THREE = 3'h3;
   localparam logic [2:0] ABEU_CYC_FOUR = 3'h4;

   // --------------------------------------------------------------
   // operations
   // --------------------------------------------------------------
   typedef enum logic [5:0] {
      OP_NOP = 6'b000000, OP_ADD = 6'b000001, OP_ADD_CARRY = 6'b000010,
      OP_WORD_ADD_IMMEDIATE = 6'b000011, OP_SUBTRACT = 6'b000100,
      OP_SUBTRACT_CONSTANT = 6'b000101, OP_SUBTRACT_WITH_BORROW = 6'b000110,
      OP_SUBTRACT_CONSTANT_WITH_BORROW = 6'b000111,
      OP_WORD_SUBTRACT_IMMEDIATE = 6'b001000, OP_AND_REG = 6'b001001,
      OP_AND_WITH_CONSTANT = 6'b001010, OP_OR_REG = 6'b001011,
      OP_OR_WITH_CONSTANT = 6'b001100, OP_EXCLUSIVE_OR = 6'b001101,
      OP_ONES_COMPLEMENT = 6'b001110, OP_TWOS_COMPLEMENT = 6'b001111,
      OP_BITS_SET = 6'b010000, OP_BITS_CLEAR = 6'b010001,
      OP_INCREMENT = 6'b010010, OP_DECREMENT = 6'b010011,
      OP_ZERO_SIGN_TEST = 6'b010100, OP_CLEAR_REG = 6'b010101,
      OP_SET_REG = 6'b010110, OP_OFFSET_JUMP = 6'b010111,
      OP_POINTER_JUMP = 6'b011000, OP_OFFSET_CALL = 6'b011001,
      OP_POINTER_CALL = 6'b011010, OP_SUBROUTINE_EXIT = 6'b011011,
      OP_INTERRUPT_EXIT = 6'b011100, OP_COMPARE_SKIP_EQUAL = 6'b011101,
      OP_COMPARE = 6'b011110, OP_COMPARE_CARRY = 6'b011111,
      OP_COMPARE_CONSTANT = 6'b100000, OP_SKIP_GPREG_BIT_LOW = 6'b100001,
      OP_SKIP_GPREG_BIT_HIGH = 6'b100010, OP_SKIP_IO_BIT_LOW = 6'b100011,
      OP_SKIP_IO_BIT_HIGH = 6'b100100, OP_BRANCH_FLAG_HIGH = 6'b100101,
      OP_BRANCH_FLAG_LOW = 6'b100110
   } abeu_op_type;

   typedef enum logic [2:0] {
      ALU_ADD = 3'b000, ALU_SUB = 3'b001, ALU_AND = 3'b010,
      ALU_OR = 3'b011, ALU_XOR = 3'b100
   } abeu_alu_fn_type;

   typedef struct packed {
      logic c;
      logic z;
      logic n;
      logic v;
      logic h;
   } abeu_alu_flags_type;

   // one instruction as handed over by the fetch stage
   typedef struct packed {
      abeu_op_type op;
      logic [7:0] rd;
      logic [7:0] rr;
      logic [7:0] k;
      logic [15:0] pair;
      logic [5:0] wk;
      logic [15:0] zptr;
      logic [2:0] bsel;
      logic io_bit;
      logic next_long;
      logic [11:0] off;
      logic [15:0] stack_top;
   } abeu_req_type;

   // effects applied when an instruction retires
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] status;
      logic wr;
      logic [7:0] data;
      logic wwr;
      logic [15:0] word;
      logic push;
      logic [15:0] rtn_addr;
   } abeu_commit_type;

   typedef struct packed {
      logic busy;
      logic ready;
      logic [1:0] cnt;
      logic retire;
      abeu_commit_type pend;
      abeu_commit_type out;
   } abeu_state_type;

endpackage

// >>> hw/abeu_alu.sv
`timescale 1ns/1ps
`default_nettype none

module abeu_alu (
   // operation select
   input wire abeu_pkg::abeu_alu_fn_type fn,
   input wire logic carry_in,
   // operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   // result
   output logic [7:0] res,
   output abeu_pkg::abeu_alu_flags_type flags
);
   import abeu_pkg::*;

   logic [8:0] sum;
   logic [8:0] dif;

   // --------------------------------------------------------------
   // byte arithmetic and logic
   // --------------------------------------------------------------
   // both sums are formed always; the select is cheaper than sharing
   always_comb begin
      sum = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
      dif = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};
      flags = '0;
      case (fn)
         ALU_ADD: begin
            res = sum[7:0];
            flags.c = sum[8];
            flags.h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            flags.v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
         end
         ALU_SUB: begin
            res = dif[7:0];
            flags.c = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
            flags.h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            flags.v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
         end
         ALU_AND: res = a & b;
         ALU_OR: res = a | b;
         ALU_XOR: res = a ^ b;
         default: res = a;
      endcase
      // logic results leave v at zero
      flags.n = res[7];
      flags.z = (res == 8'h00);
   end

endmodule
`default_nettype wire

// >>> hw/abeu_exec.sv
// Summary of operation
// - add and add-with-carry write sum, set Z C N V H, one cycle.
// - word add immediate adds constant to pair, sets Z C N V S, two cycles.
// - word subtract immediate subtracts from pair, sets Z C N V S, two cycles.
// - subtract register or constant stores difference, sets Z C N V H, one cycle.
// - subtract with borrow also subtracts carry, sets Z C N V H, one cycle.
// - and, or, xor write result, set Z N V S only, one cycle.
// - bits clear ands with inverted constant, bits set ors it; Z N V S only.
// - zero sign test ands register with itself, keeps value, sets Z N V.
// - compare constant subtracts without writing, sets Z N V C H, one cycle.
// - compare skip equal skips next instruction on match; one to three cycles.
// - register bit skip tests one bit, skips on low or high; 1-3 cycles.
// - io bit skip tests one io bit, skips on low or high; flags kept.
// - pointer jump loads pc from pointer pair in two cycles.
// - pointer call saves return address, loads pc from pointer, three cycles.
// - branch on flag high adds offset plus one; one or two cycles.
// - branch on flag low adds offset plus one; one or two cycles.
`timescale 1ns/1ps
`default_nettype none

module abeu_exec (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // instruction request
   input wire logic req_valid,
   input wire abeu_pkg::abeu_req_type req,
   output logic req_ready,
   // retirement and register write back
   output logic retire,
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic word_wr_en,
   output logic [15:0] word_data,
   // stack push for calls
   output logic push_en,
   output logic [15:0] push_data,
   // architectural state
   output logic [15:0] pc,
   output logic [7:0] status
);
   import abeu_pkg::*;

   abeu_state_type state_ff;
   abeu_state_type nxt_state;
   abeu_alu_fn_type alu_fn;
   abeu_alu_flags_type alu_flags;
   logic alu_cin;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic accept;

   assign accept = req_valid & ~state_ff.busy;

   // --------------------------------------------------------------
   // operand and function select for the byte unit
   // --------------------------------------------------------------
   // kept apart from the main decode so the unit output never feeds back
   always_comb begin
      alu_fn = ALU_ADD;
      alu_cin = 1'b0;
      alu_b = req.rr;
      case (req.op)
         OP_ADD_CARRY: alu_cin = state_ff.out.status[ABEU_FLAG_C];
         OP_SUBTRACT, OP_COMPARE, OP_COMPARE_SKIP_EQUAL, OP_TWOS_COMPLEMENT: alu_fn = ALU_SUB;
         OP_SUBTRACT_CONSTANT, OP_COMPARE_CONSTANT: begin
            alu_fn = ALU_SUB;
            alu_b = req.k;
         end
         OP_SUBTRACT_WITH_BORROW, OP_COMPARE_CARRY: begin
            alu_fn = ALU_SUB;
            alu_cin = state_ff.out.status[ABEU_FLAG_C];
         end
         OP_SUBTRACT_CONSTANT_WITH_BORROW: begin
            alu_fn = ALU_SUB;
            alu_b = req.k;
            alu_cin = state_ff.out.status[ABEU_FLAG_C];
         end
         OP_AND_REG: alu_fn = ALU_AND;
         OP_AND_WITH_CONSTANT: begin
            alu_fn = ALU_AND;
            alu_b = req.k;
         end
         OP_BITS_CLEAR: begin
            alu_fn = ALU_AND;
            alu_b = ABEU_ALL_ONES - req.k;
         end
         OP_ZERO_SIGN_TEST: begin
            alu_fn = ALU_AND;
            alu_b = req.rd;
         end
         OP_OR_REG: alu_fn = ALU_OR;
         OP_OR_WITH_CONSTANT, OP_BITS_SET: begin
            alu_fn = ALU_OR;
            alu_b = req.k;
         end
         OP_EXCLUSIVE_OR: alu_fn = ALU_XOR;
         OP_CLEAR_REG: begin
            alu_fn = ALU_XOR;
            alu_b = req.rd;
         end
         OP_ONES_COMPLEMENT: begin
            alu_fn = ALU_XOR;
            alu_b = ABEU_ALL_ONES;
         end
         OP_INCREMENT: alu_b = ABEU_ONE;
         OP_DECREMENT: begin
            alu_fn = ALU_SUB;
            alu_b = ABEU_ONE;
         end
         default: alu_b = req.rr;
      endcase
   end

   // twos complement runs as zero minus the register
   abeu_alu u_alu (
      .fn(alu_fn),
      .carry_in(alu_cin),
      .a((req.op == OP_TWOS_COMPLEMENT) ? 8'h00 : req.rd),
      .b((req.op == OP_TWOS_COMPLEMENT) ? req.rd : alu_b),
      .res(alu_res),
      .flags(alu_flags)
   );

   // --------------------------------------------------------------
   // decode, sequencing and retirement
   // --------------------------------------------------------------
   always_comb begin
      abeu_commit_type d;
      abeu_commit_type cm;
      logic [2:0] ncyc;
      logic upd_znv;
      logic upd_ch;
      logic skip;
      logic [15:0] wres;
      logic [15:0] cur_pc;
      d = state_ff.out;
      cm = state_ff.pend;
      ncyc = ABEU_CYC_ONE;
      upd_znv = 1'b0;
      upd_ch = 1'b0;
      skip = 1'b0;
      wres = 16'h0000;
      cur_pc = state_ff.out.pc;
      nxt_state = state_ff;
      d.pc = cur_pc + 16'h0001;
      d.wr = 1'b0;
      d.data = alu_res;
      d.wwr = 1'b0;
      d.word = 16'h0000;
      d.push = 1'b0;
      d.rtn_addr = cur_pc + 16'h0001;
      case (req.op)
         OP_ADD, OP_ADD_CARRY: begin
            d.wr = 1'b1;
            upd_znv = 1'b1;
            upd_ch = 1'b1;
         end
         OP_SUBTRACT, OP_SUBTRACT_CONSTANT, OP_TWOS_COMPLEMENT: begin
            d.wr = 1'b1;
            upd_znv = 1'b1;
            upd_ch = 1'b1;
         end
         OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_CONSTANT_WITH_BORROW: begin
            d.wr = 1'b1;
            upd_znv = 1'b1;
            upd_ch = 1'b1;
         end
         OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_CONSTANT: begin
            upd_znv = 1'b1;
            upd_ch = 1'b1;
         end
         OP_AND_REG, OP_AND_WITH_CONSTANT, OP_OR_REG, OP_OR_WITH_CONSTANT,
         OP_EXCLUSIVE_OR, OP_BITS_SET, OP_BITS_CLEAR, OP_CLEAR_REG,
         OP_INCREMENT, OP_DECREMENT: begin
            d.wr = 1'b1;
            upd_znv = 1'b1;
         end
         OP_ZERO_SIGN_TEST: upd_znv = 1'b1;
         OP_ONES_COMPLEMENT: begin
            d.wr = 1'b1;
            upd_znv = 1'b1;
            d.status[ABEU_FLAG_C] = 1'b1;
         end
         OP_SET_REG: begin
            d.wr = 1'b1;
            d.data = ABEU_ALL_ONES;
         end
         OP_WORD_ADD_IMMEDIATE: begin
            wres = req.pair + {10'h000, req.wk};
            d.wwr = 1'b1;
            ncyc = ABEU_CYC_TWO;
            d.status[ABEU_FLAG_V] = ~req.pair[15] & wres[15];
            d.status[ABEU_FLAG_C] = req.pair[15] & ~wres[15];
         end
         OP_WORD_SUBTRACT_IMMEDIATE: begin
            wres = req.pair - {10'h000, req.wk};
            d.wwr = 1'b1;
            ncyc = ABEU_CYC_TWO;
            d.status[ABEU_FLAG_V] = req.pair[15] & ~wres[15];
            d.status[ABEU_FLAG_C] = wres[15] & ~req.pair[15];
         end
         OP_OFFSET_JUMP: begin
            d.pc = cur_pc + {{4{req.off[11]}}, req.off} + 16'h0001;
            ncyc = ABEU_CYC_TWO;
         end
         OP_OFFSET_CALL: begin
            d.pc = cur_pc + {{4{req.off[11]}}, req.off} + 16'h0001;
            d.push = 1'b1;
            ncyc = ABEU_CYC_THREE;
         end
         OP_POINTER_JUMP: begin
            d.pc = req.zptr;
            ncyc = ABEU_CYC_TWO;
         end
         OP_POINTER_CALL: begin
            d.pc = req.zptr;
            d.push = 1'b1;
            ncyc = ABEU_CYC_THREE;
         end
         OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
            d.pc = req.stack_top;
            ncyc = ABEU_CYC_FOUR;
            if (req.op == OP_INTERRUPT_EXIT) begin
               d.status[ABEU_FLAG_I] = 1'b1;
            end
         end
         OP_COMPARE_SKIP_EQUAL: skip = (req.rd == req.rr);
         OP_SKIP_GPREG_BIT_LOW: skip = ~req.rr[req.bsel];
         OP_SKIP_GPREG_BIT_HIGH: skip = req.rr[req.bsel];
         OP_SKIP_IO_BIT_LOW: skip = ~req.io_bit;
         OP_SKIP_IO_BIT_HIGH: skip = req.io_bit;
         OP_BRANCH_FLAG_HIGH, OP_BRANCH_FLAG_LOW: begin
            if (state_ff.out.status[req.bsel] == (req.op == OP_BRANCH_FLAG_HIGH)) begin
               d.pc = cur_pc + {{9{req.off[6]}}, req.off[6:0]} + 16'h0001;
               ncyc = ABEU_CYC_TWO;
            end
         end
         default: d.wr = 1'b0;
      endcase
      // a skipped two word instruction costs one cycle more
      if (skip) begin
         d.pc = cur_pc + (req.next_long ? 16'h0003 : 16'h0002);
         ncyc = req.next_long ? ABEU_CYC_THREE : ABEU_CYC_TWO;
      end
      // word results share z and n logic with s derived from n and v
      if (d.wwr) begin
         d.word = wres;
         d.status[ABEU_FLAG_Z] = (wres == 16'h0000);
         d.status[ABEU_FLAG_N] = wres[15];
         d.status[ABEU_FLAG_S] = wres[15] ^ d.status[ABEU_FLAG_V];
      end
      if (upd_znv) begin
         d.status[ABEU_FLAG_Z] = alu_flags.z;
         d.status[ABEU_FLAG_N] = alu_flags.n;
         d.status[ABEU_FLAG_V] = alu_flags.v;
         d.status[ABEU_FLAG_S] = alu_flags.n ^ alu_flags.v;
      end
      // logic ops never reach here, so their carry and half carry hold
      if (upd_ch) begin
         d.status[ABEU_FLAG_C] = alu_flags.c;
         d.status[ABEU_FLAG_H] = alu_flags.h;
      end
      // pulses default low; pc and status hold between retirements
      nxt_state.retire = 1'b0;
      nxt_state.out.wr = 1'b0;
      nxt_state.out.wwr = 1'b0;
      nxt_state.out.push = 1'b0;
      if (state_ff.busy) begin
         nxt_state.cnt = state_ff.cnt - 2'h1;
         if (state_ff.cnt == 2'h1) begin
            nxt_state.busy = 1'b0;
            nxt_state.retire = 1'b1;
            nxt_state.out = cm;
         end
      end else if (accept) begin
         if (ncyc == ABEU_CYC_ONE) begin
            nxt_state.retire = 1'b1;
            nxt_state.out = d;
         end else begin
            nxt_state.busy = 1'b1;
            nxt_state.cnt = 2'(ncyc - ABEU_CYC_ONE);
            nxt_state.pend = d;
         end
      end
      nxt_state.ready = ~nxt_state.busy;
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_ff <= '0;
         state_ff.ready <= 1'b1;
         state_ff.out.pc <= ABEU_PC_RST;
         state_ff.out.status <= ABEU_STATUS_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // outputs come straight from the state register
   assign req_ready = state_ff.ready;
   assign retire = state_ff.retire;
   assign wr_en = state_ff.out.wr;
   assign wr_data = state_ff.out.data;
   assign word_wr_en = state_ff.out.wwr;
   assign word_data = state_ff.out.word;
   assign push_en = state_ff.out.push;
   assign push_data = state_ff.out.rtn_addr;
   assign pc = state_ff.out.pc;
   assign status = state_ff.out.status;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   add_one_cycle_a: assert property (
      accept && req.op == OP_ADD |=> retire && wr_en
         && wr_data == $past(req.rd + req.rr))
      else $error("add did not retire in one cycle");

   word_add_two_a: assert property (
      accept && req.op == OP_WORD_ADD_IMMEDIATE |=> !retire ##1
         (retire && word_wr_en && word_data == $past(req.pair + {10'h000, req.wk}, 2)))
      else $error("word add wrong result or timing");

   word_sub_two_a: assert property (
      accept && req.op == OP_WORD_SUBTRACT_IMMEDIATE |=> !retire ##1
         (retire && word_wr_en))
      else $error("word subtract not two cycles");

   logic_keeps_carry_a: assert property (
      accept && req.op inside {OP_AND_REG, OP_OR_REG, OP_EXCLUSIVE_OR} |=>
         status[ABEU_FLAG_C] == $past(status[ABEU_FLAG_C])
         && status[ABEU_FLAG_H] == $past(status[ABEU_FLAG_H])
         && !status[ABEU_FLAG_V])
      else $error("logic op disturbed carry or overflow");

   compare_no_write_a: assert property (
      accept && req.op == OP_COMPARE_CONSTANT |=> retire && !wr_en
         && status[ABEU_FLAG_Z] == ($past(req.rd) == $past(req.k)))
      else $error("compare wrote a register or wrong zero");

   skip_long_three_a: assert property (
      accept && req.op == OP_COMPARE_SKIP_EQUAL && req.rd == req.rr && req.next_long
         |=> !retire [*2] ##1 (retire && pc == $past(pc, 3) + 16'h0003))
      else $error("long skip not three cycles");

   pointer_jump_two_a: assert property (
      accept && req.op == OP_POINTER_JUMP |=> !retire ##1
         (retire && pc == $past(req.zptr, 2)))
      else $error("pointer jump wrong target or timing");

   pointer_call_three_a: assert property (
      accept && req.op == OP_POINTER_CALL |=> !retire [*2] ##1
         (retire && push_en && push_data == $past(pc, 3) + 16'h0001))
      else $error("pointer call did not push in three cycles");

   branch_untaken_a: assert property (
      accept && req.op == OP_BRANCH_FLAG_HIGH && !status[req.bsel] |=>
         retire && pc == $past(pc) + 16'h0001)
      else $error("untaken branch not one cycle");

   exit_four_cycles_a: assert property (
      accept && req.op == OP_SUBROUTINE_EXIT |=> !retire [*3] ##1
         (retire && pc == $past(req.stack_top, 4)))
      else $error("return not four cycles");

endmodule
`default_nettype wire

// >>> testbench/abeu_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

module abeu_exec_tb;
   import abeu_pkg::*;

   // ----------------------------------------------
   // clock, stimulus and device
   // ----------------------------------------------
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   abeu_req_type req = '0;
   abeu_req_type r = '0;
   logic req_ready, retire, wr_en, word_wr_en, push_en;
   logic [7:0] wr_data, status, est;
   logic [15:0] word_data, push_data, pc, epc;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   abeu_op_type lop [8] = '{OP_AND_REG, OP_AND_WITH_CONSTANT, OP_OR_REG, OP_OR_WITH_CONSTANT,
      OP_EXCLUSIVE_OR, OP_BITS_SET, OP_BITS_CLEAR, OP_ZERO_SIGN_TEST};
   logic [7:0] la [8] = '{8'hf0, 8'h0f, 8'h80, 8'h00, 8'hff, 8'h01, 8'hff, 8'h80};
   logic [7:0] lb [8] = '{8'h3c, 8'hf0, 8'h01, 8'h00, 8'h0f, 8'h80, 8'h0f, 8'h80};

   // free running clock, 40 ns period
   always #20 clk_sys = ~clk_sys;

   abeu_exec DUT (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .retire(retire), .wr_en(wr_en), .wr_data(wr_data),
      .word_wr_en(word_wr_en), .word_data(word_data), .push_en(push_en),
      .push_data(push_data), .pc(pc), .status(status));

   // ----------------------------------------------
   // tasks
   // ----------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // offer one instruction at a falling edge, then count cycles up to retirement
   task automatic go(input abeu_op_type op, input int ncyc, input logic [15:0] npc);
      int n;
      r.op = op;
      @(negedge clk_sys);
      req = r;
      req_valid = 1'b1;
      @(negedge clk_sys);
      req_valid = 1'b0;
      n = 1;
      while (retire !== 1'b1 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      chk(16'(n), 16'(ncyc), "cycles");
      chk(pc, npc, "next pc");
      chk({8'h00, status}, {8'h00, est}, "flags");
      epc = npc;
   endtask

   task automatic alu(input abeu_op_type op, input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] d, input logic w, input logic [7:0] st);
      r.rd = a;
      r.rr = b;
      r.k = b;
      est = st;
      go(op, 1, epc + 16'h0001);
      chk({15'h0, wr_en}, {15'h0, w}, "byte write");
      chk({8'h00, wr_data & {8{w}}}, {8'h00, d & {8{w}}}, "byte result");
   endtask

   task automatic wop(input abeu_op_type op, input logic [15:0] p, input logic [5:0] k,
      input logic [15:0] d, input logic [7:0] st);
      r.pair = p;
      r.wk = k;
      est = st;
      go(op, 2, epc + 16'h0001);
      chk({15'h0, word_wr_en}, 16'h0001, "word write");
      chk(word_data, d, "word result");
   endtask

   // skip length follows the width of the instruction being jumped over
   task automatic skp(input abeu_op_type op, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] s, input logic io, input logic lng, input logic take);
      int n;
      n = take ? (lng ? 3 : 2) : 1;
      r.rd = a;
      r.rr = b;
      r.bsel = s;
      r.io_bit = io;
      r.next_long = lng;
      go(op, n, epc + 16'(n));
   endtask

   function automatic logic [7:0] lres(input int i);
      case (i)
         0, 1: lres = la[i] & lb[i];
         2, 3, 5: lres = la[i] | lb[i];
         4: lres = la[i] ^ lb[i];
         6: lres = la[i] & (8'hff - lb[i]);
         default: lres = la[i];
      endcase
   endfunction

   // ----------------------------------------------
   // test sequence
   // ----------------------------------------------
   initial begin
      logic [7:0] d;
      logic [7:0] st;
      est = 8'h00;
      epc = 16'h0000;
      repeat (16) @(negedge clk_sys);
      chk(pc, 16'h0000, "reset pc");
      chk({15'h0, req_ready}, 16'h0001, "reset ready");
      reset_n = 1'b1;
      alu(OP_ADD, 8'h0f, 8'h01, 8'h10, 1'b1, 8'h20);
      alu(OP_ADD, 8'h80, 8'h80, 8'h00, 1'b1, 8'h1b);
      alu(OP_ADD_CARRY, 8'h01, 8'h01, 8'h03, 1'b1, 8'h00);
      alu(OP_SUBTRACT, 8'h10, 8'h01, 8'h0f, 1'b1, 8'h20);
      alu(OP_SUBTRACT_CONSTANT, 8'h00, 8'h01, 8'hff, 1'b1, 8'h35);
      alu(OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 8'hff, 1'b1, 8'h35);
      // carry and half carry stay set through the logic ops
      for (int i = 0; i < 8; i++) begin
         d = lres(i);
         st = (est & 8'he1) | {3'b000, d[7], 1'b0, d[7], d == 8'h00, 1'b0};
         alu(lop[i], la[i], lb[i], d, i != 7, st);
      end
      alu(OP_SUBTRACT_CONSTANT_WITH_BORROW, 8'h80, 8'h01, 8'h7e, 1'b1, 8'h38);
      alu(OP_ONES_COMPLEMENT, 8'h5a, 8'h00, 8'ha5, 1'b1, 8'h35);
      alu(OP_TWOS_COMPLEMENT, 8'h80, 8'h00, 8'h80, 1'b1, 8'h0d);
      alu(OP_COMPARE_CONSTANT, 8'h05, 8'h05, 8'h00, 1'b0, 8'h02);
      alu(OP_COMPARE_CONSTANT, 8'h10, 8'h20, 8'h00, 1'b0, 8'h15);
      wop(OP_WORD_ADD_IMMEDIATE, 16'hfffe, 6'h02, 16'h0000, 8'h03);
      wop(OP_WORD_ADD_IMMEDIATE, 16'h7fff, 6'h01, 16'h8000, 8'h0c);
      wop(OP_WORD_SUBTRACT_IMMEDIATE, 16'h0000, 6'h01, 16'hffff, 8'h15);
      wop(OP_WORD_SUBTRACT_IMMEDIATE, 16'h8000, 6'h01, 16'h7fff, 8'h18);
      r.bsel = 3'h3;
      r.off = 12'h07e;
      go(OP_BRANCH_FLAG_HIGH, 2, epc - 16'h0001);
      go(OP_BRANCH_FLAG_LOW, 1, epc + 16'h0001);
      r.bsel = 3'h0;
      r.off = 12'hf85;
      go(OP_BRANCH_FLAG_LOW, 2, epc + 16'h0006);
      go(OP_BRANCH_FLAG_HIGH, 1, epc + 16'h0001);
      skp(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 3'h0, 1'b0, 1'b0, 1'b1);
      skp(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 3'h0, 1'b0, 1'b1, 1'b1);
      skp(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h32, 3'h0, 1'b0, 1'b1, 1'b0);
      skp(OP_SKIP_GPREG_BIT_LOW, 8'hf7, 8'hf7, 3'h3, 1'b0, 1'b1, 1'b1);
      skp(OP_SKIP_GPREG_BIT_HIGH, 8'hf7, 8'hf7, 3'h3, 1'b0, 1'b0, 1'b0);
      skp(OP_SKIP_GPREG_BIT_HIGH, 8'h08, 8'h08, 3'h3, 1'b0, 1'b0, 1'b1);
      skp(OP_SKIP_IO_BIT_LOW, 8'hff, 8'hff, 3'h0, 1'b0, 1'b0, 1'b1);
      skp(OP_SKIP_IO_BIT_LOW, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0, 1'b0);
      skp(OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h00, 3'h0, 1'b1, 1'b1, 1'b1);
      r.zptr = 16'h1234;
      go(OP_POINTER_JUMP, 2, 16'h1234);
      r.zptr = 16'h0200;
      go(OP_POINTER_CALL, 3, 16'h0200);
      chk({15'h0, push_en}, 16'h0001, "push strobe");
      chk(push_data, 16'h1235, "return address");
      r.off = 12'hffe;
      go(OP_OFFSET_JUMP, 2, 16'h01ff);
      r.off = 12'h010;
      go(OP_OFFSET_CALL, 3, 16'h0210);
      chk({15'h0, push_en}, 16'h0001, "push strobe");
      chk(push_data, 16'h0200, "return address");
      r.stack_top = 16'h0456;
      go(OP_SUBROUTINE_EXIT, 4, 16'h0456);
      est = est | 8'h80;
      go(OP_INTERRUPT_EXIT, 4, 16'h0456);
      r.bsel = 3'h7;
      r.off = 12'h002;
      go(OP_BRANCH_FLAG_HIGH, 2, 16'h0459);
      finish_test();
   end

   // cut a hang short; the whole sequence needs under two hundred cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         finish_test();
      end
   end

endmodule

`default_nettype wire
